// ===== hdl/rss_reset_sequencer.sv
// Reset source sequencer: power, watchdog and external reset with cause flags
// What this block does
// - Hold reset while supply low, then 65536-clock warm-up
// - Every reset exit starts fetch at 0000h
// - Power-on or brownout sets power-on flag, bit 6
// - Supply drop re-enters reset, recovery repeats power-up
// - Watchdog time-out with watchdog and reset enable holds reset two machine cycles
// - Watchdog time-out with reset enable sets flag, bit 2
// - External reset needs two machine cycles high first
// - Hold while external high, exit two cycles after
// - No external flag; implied when both flags clear
// - External reset in stop mode uses full warm-up
// - Active-low reset output during every reset state
`timescale 1ns/10ps
`include "rss_consts.svh"
module rss_reset_sequencer #(
  parameter int unsigned WARMUP_CLKS = `RSS_WARMUP_CLKS,
  parameter int unsigned CLKS_PER_MC = `RSS_CLKS_PER_MC,
  parameter int unsigned WDT_RST_MC  = `RSS_WDT_RST_MC,
  parameter int unsigned EXT_DET_MC  = `RSS_EXT_DET_MC,
  parameter int unsigned EXT_EXIT_MC = `RSS_EXT_EXIT_MC
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                reset,
  // Asynchronous pins
  input  wire logic                supply_ok_pin,
  input  wire logic                ext_reset_pin,
  // Core-side controls and events
  input  wire rss_pkg::rss_ctrl_s  ctrl,
  input  wire logic                wdt_timeout,
  input  wire logic                osc_fail,
  input  wire logic                clear_por,
  input  wire logic                clear_wdt_flag,
  // Reset outputs
  output logic                     cpu_reset,
  output logic                     reset_out_low_n,
  output logic                     osc_enable,
  output logic                     pc_load,
  output logic [15:0]              pc_vector,
  // Cause flags
  output rss_pkg::rss_cause_s      cause,
  output logic [7:0]               watchdog_control_reg
);
  import rss_pkg::*;

  localparam int WU_W = $clog2(WARMUP_CLKS + 1);
  localparam int DV_W = $clog2(CLKS_PER_MC + 1);
  localparam int HC_W = 4;
  localparam int WU_LAST   = WARMUP_CLKS - 1;
  localparam int WDT_LAST  = WDT_RST_MC * CLKS_PER_MC - 1;
  localparam int DET_CLKS  = EXT_DET_MC * CLKS_PER_MC;
  localparam int EXIT_MAX  = EXT_EXIT_MC * CLKS_PER_MC + 2;

  rss_state_e        state;
  rss_state_e        next_state;
  logic              supply_hi;
  logic              ext_hi;
  logic              ext_hi_d;
  logic [WU_W-1:0]   wu_cnt;
  logic [DV_W-1:0]   div_cnt;
  logic [HC_W-1:0]   hold_cnt;
  logic [HC_W-1:0]   ext_mc_cnt;
  logic              mc_tick;
  logic              div_clr;
  logic              ext_rise;
  logic              ext_det;
  logic              wdt_fire;
  logic              osc_fault;
  rss_cause_s        next_cause;

  function automatic logic in_reset(input rss_state_e st);
    in_reset = (st != ST_RUN);
  endfunction

  rss_pin_sync #(.RST_VAL(`RSS_PIN_RST)) u_supply_sync (
    .mclk  (mclk),
    .reset (reset),
    .pin   (supply_ok_pin),
    .level (supply_hi)
  );

  rss_pin_sync #(.RST_VAL(`RSS_PIN_RST)) u_ext_sync (
    .mclk  (mclk),
    .reset (reset),
    .pin   (ext_reset_pin),
    .level (ext_hi)
  );

  assign osc_fault = osc_fail && ctrl.osc_fail_detect_enable;
  assign wdt_fire  = wdt_timeout && ctrl.watchdog_enable && ctrl.watchdog_reset_enable;
  assign ext_rise  = ext_hi && !ext_hi_d;
  assign mc_tick   = (div_cnt == DV_W'(CLKS_PER_MC - 1));
  assign ext_det   = ext_hi && mc_tick && (ext_mc_cnt == HC_W'(EXT_DET_MC - 1));
  // Realign machine cycles on state change so hold times are exact
  assign div_clr   = (state != next_state) || ((state == ST_RUN) && ext_rise);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POWER_LOW:
        if (supply_hi)
          next_state = ST_WARMUP;
      ST_WARMUP:
        if (wu_cnt == WU_W'(WARMUP_CLKS - 1))
          next_state = ext_hi ? ST_EXT_HOLD : ST_RUN;
      ST_RUN:
        if (osc_fault)
          next_state = ST_OSC_FAIL;
        else if (ctrl.stop_mode && ext_hi)
          next_state = ST_WARMUP;
        else if (ext_det)
          next_state = ST_EXT_HOLD;
        else if (wdt_fire)
          next_state = ST_WDT_HOLD;
      ST_WDT_HOLD:
        if (mc_tick && (hold_cnt == HC_W'(WDT_RST_MC - 1)))
          next_state = ST_RUN;
      ST_EXT_HOLD:
        if (!ext_hi)
          next_state = ST_EXT_EXIT;
      ST_EXT_EXIT:
        if (ext_hi)
          next_state = ST_EXT_HOLD;
        else if (mc_tick && (hold_cnt == HC_W'(EXT_EXIT_MC - 1)))
          next_state = ST_RUN;
      ST_OSC_FAIL:
        if (!osc_fault)
          next_state = ST_WARMUP;
    endcase
    // Brownout overrides every other source
    if (!supply_hi)
      next_state = ST_POWER_LOW;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state <= ST_POWER_LOW;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ext_hi_d <= 1'b0;
    else
      ext_hi_d <= ext_hi;
  end

  // Warm-up counter; runs only while in warm-up
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      wu_cnt <= '0;
    else if (state != ST_WARMUP || next_state != ST_WARMUP)
      wu_cnt <= '0;
    else
      wu_cnt <= wu_cnt + WU_W'(1);
  end

  // Machine-cycle divider
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      div_cnt <= '0;
    else if (div_clr || mc_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + DV_W'(1);
  end

  // Machine cycles spent in a timed hold state
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      hold_cnt <= '0;
    else if (state != next_state)
      hold_cnt <= '0;
    else if (mc_tick)
      hold_cnt <= hold_cnt + HC_W'(1);
  end

  // Machine cycles that the external pin has stayed high while running
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ext_mc_cnt <= '0;
    else if (!ext_hi || state != ST_RUN || ext_rise)
      ext_mc_cnt <= '0;
    else if (mc_tick)
      ext_mc_cnt <= ext_mc_cnt + HC_W'(1);
  end

  // Only two cause flags exist; external reset is their absence
  always_comb
  begin
    next_cause = cause;
    if (state == ST_POWER_LOW)
      next_cause.por = 1'b1;
    else if (clear_por)
      next_cause.por = 1'b0;
    if (state == ST_RUN && next_state == ST_WDT_HOLD)
      next_cause.watchdog_reset_flag = 1'b1;
    else if (clear_wdt_flag)
      next_cause.watchdog_reset_flag = 1'b0;
  end

  // Flags sit outside the reset sequence so other resets keep them
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cause.por                 <= `RSS_POR_RST;
      cause.watchdog_reset_flag <= `RSS_WDT_FLAG_RST;
    end
    else
      cause <= next_cause;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      watchdog_control_reg                <= 8'h00;
      watchdog_control_reg[`RSS_POR_BIT]  <= `RSS_POR_RST;
      watchdog_control_reg[`RSS_WDT_FLAG_BIT] <= `RSS_WDT_FLAG_RST;
    end
    else
    begin
      watchdog_control_reg                <= 8'h00;
      watchdog_control_reg[`RSS_POR_BIT]  <= next_cause.por;
      watchdog_control_reg[`RSS_WDT_FLAG_BIT] <= next_cause.watchdog_reset_flag;
    end
  end

  // Outputs are taken from the next state so they line up with it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cpu_reset       <= 1'b1;
      reset_out_low_n <= 1'b0;
    end
    else
    begin
      cpu_reset       <= in_reset(next_state);
      reset_out_low_n <= !in_reset(next_state);
    end
  end

  // Oscillator stops in stop mode and while supply is low
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      osc_enable <= 1'b0;
    else
      osc_enable <= !((next_state == ST_POWER_LOW) ||
                      (next_state == ST_RUN && ctrl.stop_mode));
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pc_load   <= 1'b0;
      pc_vector <= `RSS_RESET_VECTOR;
    end
    else
    begin
      pc_load   <= in_reset(state) && !in_reset(next_state);
      pc_vector <= `RSS_RESET_VECTOR;
    end
  end

  // Helper counters for the checks below
  logic [WU_W-1:0] wu_len;
  logic [HC_W+DV_W-1:0] wdt_len;
  logic [15:0] ext_len;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wu_len  <= '0;
      wdt_len <= '0;
      ext_len <= '0;
    end
    else
    begin
      wu_len  <= (state == ST_WARMUP) ? wu_len + WU_W'(1) : '0;
      wdt_len <= (state == ST_WDT_HOLD) ? wdt_len + (HC_W+DV_W)'(1) : '0;
      if (!ext_hi)
        ext_len <= '0;
      else if (ext_len != 16'hffff)
        ext_len <= ext_len + 16'h0001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  supply_hold_a: assert property (!supply_hi |=> cpu_reset && !reset_out_low_n)
    else $error("reset not held while supply low");
  warmup_len_a: assert property ((state == ST_WARMUP && next_state != ST_WARMUP
                                  && supply_hi) |-> wu_len == WU_LAST)
    else $error("warm-up length wrong");
  vector_load_a: assert property ($fell(cpu_reset) |-> pc_load && pc_vector == 16'h0000)
    else $error("reset exit without vector load");
  por_set_a: assert property ((state == ST_POWER_LOW) |=> cause.por
                              && watchdog_control_reg[6])
    else $error("power-on flag not set");
  wdt_hold_a: assert property ((state == ST_WDT_HOLD && next_state == ST_RUN)
                               |-> wdt_len == WDT_LAST)
    else $error("watchdog reset length wrong");
  wdt_flag_a: assert property ((state == ST_RUN && next_state == ST_WDT_HOLD)
                               |=> cause.watchdog_reset_flag && watchdog_control_reg[2])
    else $error("watchdog flag not set");
  ext_detect_a: assert property ((state == ST_RUN && next_state == ST_EXT_HOLD)
                                 |-> ext_len >= DET_CLKS)
    else $error("external reset taken too early");
  ext_hold_a: assert property ((state == ST_EXT_HOLD && ext_hi) |=> cpu_reset)
    else $error("reset dropped while pin high");
  ext_exit_a: assert property ((state == ST_EXT_HOLD && !ext_hi) |->
                               ##[1:EXIT_MAX] (!cpu_reset || ext_hi || !supply_hi))
    else $error("external reset exit too slow");
  stop_ext_a: assert property ((state == ST_RUN && ctrl.stop_mode && ext_hi && supply_hi
                                && !osc_fault) |=> state == ST_WARMUP)
    else $error("stop-mode reset skipped warm-up");
  rst_out_a: assert property (reset_out_low_n == !cpu_reset
                              && (cpu_reset == (state != ST_RUN)))
    else $error("reset output mismatch");
  flag_keep_a: assert property ((state != ST_POWER_LOW && !clear_por)
                                |=> cause.por == $past(cause.por))
    else $error("power-on flag changed without cause");
endmodule // rss_reset_sequencer

// ===== hdl/rss_consts.svh
// Reset sequencer constants: counts, bit positions and reset values
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
`define RSS_WARMUP_CLKS   65536
`define RSS_CLKS_PER_MC   4
`define RSS_WDT_RST_MC    2
`define RSS_EXT_DET_MC    2
`define RSS_EXT_EXIT_MC   2
`define RSS_RESET_VECTOR  16'h0000
`define RSS_POR_BIT       6
`define RSS_WDT_FLAG_BIT  2
`define RSS_POR_RST       1'b1
`define RSS_WDT_FLAG_RST  1'b0
`define RSS_PIN_RST       1'b0
`endif

// ===== hdl/rss_pkg.sv
// Types shared by the reset source sequencer
package rss_pkg;
  typedef enum logic [2:0] {
    ST_POWER_LOW,
    ST_WARMUP,
    ST_RUN,
    ST_WDT_HOLD,
    ST_EXT_HOLD,
    ST_EXT_EXIT,
    ST_OSC_FAIL
  } rss_state_e;

  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_reset_enable;
    logic osc_fail_detect_enable;
    logic stop_mode;
  } rss_ctrl_s;

  typedef struct packed {
    logic por;
    logic watchdog_reset_flag;
  } rss_cause_s;
endpackage

// ===== hdl/rss_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rss_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic ff1;
  logic ff2;
  logic ff3;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
    end
    else
    begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Level moves only once the last two stages agree
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      level <= RST_VAL;
    else if (ff2 == ff3)
      level <= ff3;
  end
endmodule // rss_pin_sync

// ===== sim/rss_board_model.sv
// Board model: supply monitor and reset button, watches the reset output
`timescale 1ns/10ps
module rss_board_model (
  // Clock and observed reset output
  input  wire logic mclk,
  input  wire logic reset_out_low_n,
  // Driven pins
  output logic      supply_ok_pin,
  output logic      ext_reset_pin
);
  int resets_seen = 0;

  initial
  begin
    supply_ok_pin = 1'b1;
    ext_reset_pin = 1'b0;
  end

  // Counts reset entries as an external device would see them
  always @(negedge reset_out_low_n)
    resets_seen++;

  // Pins change just after an edge and hold for the given cycles
  task automatic drive(input logic sup, input logic ext, input int cycles);
    supply_ok_pin = sup;
    ext_reset_pin = ext;
    // A zero count returns at once so the caller keeps the usual offset
    repeat (cycles)
    begin
      @(posedge mclk);
      #2;
    end
  endtask
endmodule // rss_board_model

// ===== sim/tb_rss_reset_sequencer.sv
// Self-checking testbench for the reset source sequencer
`timescale 1ns/10ps
module tb_rss_reset_sequencer;
  import rss_pkg::*;
  // Short warm-up keeps the run brief; the warm-up expectations derive from it
  localparam int W = 16;
  logic        mclk, reset, supply_ok_pin, ext_reset_pin;
  logic        wdt_timeout, osc_fail, clear_por, clear_wdt_flag;
  rss_ctrl_s   ctrl;
  logic        cpu_reset, reset_out_low_n, osc_enable, pc_load;
  logic [15:0] pc_vector;
  rss_cause_s  cause;
  logic [7:0]  watchdog_control_reg;
  int          fail_count = 0;
  int          comparisons = 0;
  int          base;

  rss_reset_sequencer #(.WARMUP_CLKS(W)) u_rss_reset_sequencer (
    .mclk(mclk), .reset(reset), .supply_ok_pin(supply_ok_pin),
    .ext_reset_pin(ext_reset_pin), .ctrl(ctrl), .wdt_timeout(wdt_timeout),
    .osc_fail(osc_fail), .clear_por(clear_por), .clear_wdt_flag(clear_wdt_flag),
    .cpu_reset(cpu_reset), .reset_out_low_n(reset_out_low_n),
    .osc_enable(osc_enable), .pc_load(pc_load), .pc_vector(pc_vector),
    .cause(cause), .watchdog_control_reg(watchdog_control_reg));

  rss_board_model u_rss_board_model (
    .mclk(mclk), .reset_out_low_n(reset_out_low_n),
    .supply_ok_pin(supply_ok_pin), .ext_reset_pin(ext_reset_pin));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    #2;
  endtask

  // Counts reset cycles up to the exit; bounded so a stuck reset ends the run
  task automatic measure(input int lo, input int hi);
    int n = 0;
    for (int i = 0; i < 4000; i++)
    begin
      tick(1);
      check(reset_out_low_n, !cpu_reset);
      if (cpu_reset === 1'b1)
        n++;
      else if (n > 0)
      begin
        check(pc_load, 1'b1);
        check(pc_vector, 16'h0000);
        check(n >= lo && n <= hi, 1'b1);
        return;
      end
    end
    fail_count++;
    test_done();
  endtask

  task automatic quiet(input int c);
    repeat (c)
    begin
      tick(1);
      check(cpu_reset, 1'b0);
    end
  endtask

  task automatic pulse_clear(input logic por_sel);
    clear_por = por_sel;
    clear_wdt_flag = !por_sel;
    tick(1);
    clear_por = 1'b0;
    clear_wdt_flag = 1'b0;
    tick(1);
  endtask

  initial
  begin
    reset = 1'b1;
    ctrl = '0;
    wdt_timeout = 1'b0;
    osc_fail = 1'b0;
    clear_por = 1'b0;
    clear_wdt_flag = 1'b0;
    tick(20);
    reset = 1'b0;
    measure(W, W + 6);
    check(cause.por, 1'b1);
    check(watchdog_control_reg, 8'h40);
    base = u_rss_board_model.resets_seen;
    pulse_clear(1'b1);
    check(watchdog_control_reg, 8'h00);
    // Watchdog without its reset enable must not reset
    ctrl.watchdog_enable = 1'b1;
    wdt_timeout = 1'b1;
    tick(1);
    wdt_timeout = 1'b0;
    quiet(12);
    ctrl.watchdog_reset_enable = 1'b1;
    wdt_timeout = 1'b1;
    tick(1);
    wdt_timeout = 1'b0;
    // First of the eight reset cycles is seen here, measure counts the rest
    check(cpu_reset, 1'b1);
    check(cause.watchdog_reset_flag, 1'b1);
    measure(7, 7);
    check(watchdog_control_reg, 8'h04);
    // Short external pulse is filtered out
    u_rss_board_model.drive(1'b1, 1'b1, 5);
    u_rss_board_model.drive(1'b1, 1'b0, 0);
    quiet(12);
    u_rss_board_model.drive(1'b1, 1'b1, 24);
    check(cpu_reset, 1'b1);
    u_rss_board_model.drive(1'b1, 1'b0, 0);
    measure(8, 13);
    check(watchdog_control_reg, 8'h04);
    pulse_clear(1'b0);
    check(watchdog_control_reg, 8'h00);
    // Brownout repeats the power-up sequence
    u_rss_board_model.drive(1'b0, 1'b0, 8);
    check(cpu_reset, 1'b1);
    check(cause.por, 1'b1);
    u_rss_board_model.drive(1'b1, 1'b0, 0);
    measure(W, W + 6);
    pulse_clear(1'b1);
    ctrl.stop_mode = 1'b1;
    tick(2);
    check(osc_enable, 1'b0);
    // Stop mode must still stand when the synchronised pin reaches the core
    u_rss_board_model.drive(1'b1, 1'b1, 5);
    check(cpu_reset, 1'b1);
    check(osc_enable, 1'b1);
    u_rss_board_model.drive(1'b1, 1'b0, 0);
    ctrl.stop_mode = 1'b0;
    measure(W - 1, W - 1);
    ctrl.osc_fail_detect_enable = 1'b1;
    osc_fail = 1'b1;
    tick(6);
    check(reset_out_low_n, 1'b0);
    osc_fail = 1'b0;
    measure(W, W + 2);
    check(16'(u_rss_board_model.resets_seen - base), 16'h0005);
    test_done();
  end
endmodule // tb_rss_reset_sequencer
